// [hw/smx_device.sv]
`timescale 1ns/1ns
`default_nettype none
`include "smx_regs.svh"

module smx_device (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	smx_link_if.device link,
	output logic [7:0] channel_on_o,
	output logic break_o,
	output logic [3:0] word_o,
	output logic sel_high_o,
	output logic [2:0] frame_bits_o
);
	logic [3:0] shift;
	logic sclk_s;
	logic sel_s;
	logic sel_q;
	logic [3:0] word_s;
	logic sclk_q;
	logic sel_fall;
	logic [7:0] pending;
	logic [7:0] cnt;
	smx_pkg::smx_dev_state_t state;

	// link side runs only on the serial clock, no reset exists there

	// register moves only on rising edges while select is high
	always_ff @(posedge link.sclk)
	begin
		if (link.sel)
		begin
			shift <= {shift[2:0], link.din};
		end
	end

	// oldest bit leaves after the fourth rising edge
	assign link.dout = shift[3];

	// released while select is low
	assign link.dout_oe = link.sel;

	// crossings into the system clock domain
	smx_sync2 #(
		.WIDTH(1)
	) u_sync_sel (
		.clk_i(sys_clk_i),
		.d_i(link.sel),
		.q_o(sel_s)
	);

	// the register is frozen while select is low, so the word is
	// stable by the time the synchronised select shows the fall
	smx_sync2 #(
		.WIDTH(4)
	) u_sync_word (
		.clk_i(sys_clk_i),
		.d_i(shift),
		.q_o(word_s)
	);

	// serial clock sampled only to count frame bits for status
	smx_sync2 #(
		.WIDTH(1)
	) u_sync_sclk (
		.clk_i(sys_clk_i),
		.d_i(link.sclk),
		.q_o(sclk_s)
	);

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			sel_q <= 1'b0;
		end
		else
		begin
			sel_q <= sel_s;
		end
	end

	assign sel_fall = sel_q & ~sel_s;

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			sel_high_o <= 1'b0;
			sclk_q <= 1'b0;
			frame_bits_o <= 3'h0;
		end
		else
		begin
			sel_high_o <= sel_s;
			sclk_q <= sclk_s;
			// one count per rising serial clock while select is high
			if (sel_s && sclk_s && !sclk_q)
			begin
				frame_bits_o <= frame_bits_o + 3'h1;
			end
		end
	end

	// word and decode are taken once per select fall and then held
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			word_o <= 4'h0;
			pending <= 8'h00;
		end
		else if (sel_fall)
		begin
			word_o <= word_s;
			pending <= smx_pkg::smx_decode(word_s);
		end
	end

	// switch sequencing: open everything at once, wait the gap, close
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			state <= smx_pkg::SMX_DEV_HOLD;
			cnt <= 8'h00;
		end
		else if (sel_fall)
		begin
			state <= smx_pkg::SMX_DEV_BREAK;
			cnt <= 8'(`SMX_BREAK_CYC - 1);
		end
		else
		begin
			case (state)
				smx_pkg::SMX_DEV_HOLD:
				begin
					cnt <= 8'h00;
				end
				smx_pkg::SMX_DEV_BREAK:
				begin
					if (cnt == 8'h00)
					begin
						state <= smx_pkg::SMX_DEV_HOLD;
					end
					else
					begin
						cnt <= cnt - 8'h01;
					end
				end
				default:
				begin
					state <= smx_pkg::SMX_DEV_HOLD;
					cnt <= 8'h00;
				end
			endcase
		end
	end

	// switch drive: opened in the cycle the fall is seen, closed when
	// the gap has run out; stays until the next fall
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			channel_on_o <= 8'h00;
		end
		else if (sel_fall)
		begin
			channel_on_o <= 8'h00;
		end
		else if (state == smx_pkg::SMX_DEV_BREAK && cnt == 8'h00)
		begin
			channel_on_o <= pending;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			break_o <= 1'b0;
		end
		else if (sel_fall)
		begin
			break_o <= 1'b1;
		end
		else if (state == smx_pkg::SMX_DEV_BREAK && cnt == 8'h00)
		begin
			break_o <= 1'b0;
		end
	end
endmodule

`default_nettype wire

// [hw/smx_host.sv]
`timescale 1ns/1ns
`default_nettype none
`include "smx_regs.svh"

module smx_host (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	smx_link_if.host link
);
	logic [31:0] data;
	logic [31:0] cfg;
	logic [31:0] rx;
	logic [31:0] tx;
	logic [5:0] bits_left;
	logic [7:0] cnt;
	logic [7:0] half;
	logic miso_s;
	logic go;
	logic busy;
	smx_pkg::smx_host_state_t state;

	smx_sync2 #(
		.WIDTH(1)
	) u_sync_miso (
		.clk_i(sys_clk_i),
		.d_i(link.dout_line),
		.q_o(miso_s)
	);

	assign busy = (state != smx_pkg::SMX_HOST_IDLE);
	assign go = wr_i && addr_i == `SMX_REG_CTRL && wdata_i[`SMX_CTRL_GO_POS];
	assign half = cfg[`SMX_CFG_HALF_MSB:`SMX_CFG_HALF_LSB];

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			data <= 32'h0000_0000;
			cfg <= `SMX_CFG_RESET;
		end
		else if (wr_i && addr_i == `SMX_REG_DATA)
		begin
			data <= wdata_i;
		end
		else if (wr_i && addr_i == `SMX_REG_CFG && !busy)
		begin
			cfg <= {16'h0000, wdata_i[15:8] < 8'(`SMX_HALF_MIN_CYC) ?
				8'(`SMX_HALF_MIN_CYC) : wdata_i[15:8], 5'h00, wdata_i[2:0]};
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			rdata_o <= 32'h0000_0000;
		end
		else if (rd_i)
		begin
			case (addr_i)
				`SMX_REG_DATA: rdata_o <= data;
				`SMX_REG_CFG: rdata_o <= cfg;
				`SMX_REG_CTRL: rdata_o <= {31'h0, busy};
				`SMX_REG_RX: rdata_o <= rx;
				default: rdata_o <= 32'h0000_0000;
			endcase
		end
		else
		begin
			rdata_o <= 32'h0000_0000;
		end
	end

	// frame: four bits per device, farthest device's word first
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			state <= smx_pkg::SMX_HOST_IDLE;
			link.sclk <= 1'b0;
			link.sel <= 1'b0;
			link.din <= 1'b0;
			tx <= 32'h0000_0000;
			rx <= 32'h0000_0000;
			bits_left <= 6'h00;
			cnt <= 8'h00;
		end
		else
		begin
			case (state)
				smx_pkg::SMX_HOST_IDLE:
				begin
					if (go)
					begin
						tx <= data << (6'd28 - {cfg[2:0], 2'b00});
						link.din <= data[{cfg[2:0], 2'b11}];
						link.sel <= 1'b1;
						bits_left <= {1'b0, cfg[2:0], 2'b11};
						cnt <= half - 8'h01;
						state <= smx_pkg::SMX_HOST_LOW;
					end
				end
				smx_pkg::SMX_HOST_LOW:
				begin
					if (cnt == 8'h00)
					begin
						rx <= {rx[30:0], miso_s};
						link.sclk <= 1'b1;
						cnt <= half - 8'h01;
						state <= smx_pkg::SMX_HOST_HIGH;
					end
					else
					begin
						cnt <= cnt - 8'h01;
					end
				end
				smx_pkg::SMX_HOST_HIGH:
				begin
					if (cnt != 8'h00)
					begin
						cnt <= cnt - 8'h01;
					end
					else if (bits_left == 6'h00)
					begin
						// select drops with the falling clock, no further rise
						link.sclk <= 1'b0;
						link.sel <= 1'b0;
						cnt <= 8'(`SMX_ON_MAX_CYC);
						state <= smx_pkg::SMX_HOST_GAP;
					end
					else
					begin
						link.sclk <= 1'b0;
						link.din <= tx[30];
						tx <= tx << 1;
						bits_left <= bits_left - 6'h01;
						cnt <= half - 8'h01;
						state <= smx_pkg::SMX_HOST_LOW;
					end
				end
				smx_pkg::SMX_HOST_GAP:
				begin
					// let the switches settle before another frame
					if (cnt == 8'h00)
					begin
						state <= smx_pkg::SMX_HOST_IDLE;
					end
					else
					begin
						cnt <= cnt - 8'h01;
					end
				end
				default:
				begin
					state <= smx_pkg::SMX_HOST_IDLE;
				end
			endcase
		end
	end
endmodule

`default_nettype wire

// [hw/smx_link_if.sv]
`timescale 1ns/1ns
`default_nettype none

interface smx_link_if;
	logic sclk;
	logic sel;
	logic din;
	logic dout;
	logic dout_oe;
	logic dout_line;

	// released output idles high on the board
	assign dout_line = dout_oe ? dout : 1'b1;

	modport host (
		output sclk,
		output sel,
		output din,
		input dout_line
	);

	modport device (
		input sclk,
		input sel,
		input din,
		output dout,
		output dout_oe
	);
endinterface

`default_nettype wire

// [hw/smx_pkg.sv]
`default_nettype none

package smx_pkg;

	typedef enum logic [1:0] {
		SMX_DEV_HOLD = 2'b01,
		SMX_DEV_BREAK = 2'b10
	} smx_dev_state_t;

	typedef enum logic [3:0] {
		SMX_HOST_IDLE = 4'b0001,
		SMX_HOST_LOW = 4'b0010,
		SMX_HOST_HIGH = 4'b0100,
		SMX_HOST_GAP = 4'b1000
	} smx_host_state_t;

	// control word to one-hot switch pattern; enable low opens all
	function automatic logic [7:0] smx_decode(input logic [3:0] word);
		logic [7:0] hot;
		hot = 8'h00;
		if (word[3])
			hot[word[2:0]] = 1'b1;
		return hot;
	endfunction

endpackage

`default_nettype wire

// [hw/smx_regs.svh]
`ifndef SMX_REGS_SVH
`define SMX_REGS_SVH

// control word layout, first bit sent sits at the top
`define SMX_WORD_BITS 4
`define SMX_EN_POS 3
`define SMX_IDX_MSB 2
`define SMX_IDX_LSB 0
`define SMX_CHANNELS 8

// system clock
`define SMX_SYS_PERIOD_NS 4

// switch timing in ns and in system clock cycles
`define SMX_T_BREAK_NS 125
`define SMX_T_ON_NS 800
`define SMX_T_OFF_NS 400
`define SMX_BREAK_CYC \
	((`SMX_T_BREAK_NS + `SMX_SYS_PERIOD_NS - 1) / `SMX_SYS_PERIOD_NS)
`define SMX_ON_MAX_CYC (`SMX_T_ON_NS / `SMX_SYS_PERIOD_NS)
`define SMX_OFF_MAX_CYC (`SMX_T_OFF_NS / `SMX_SYS_PERIOD_NS)

// serial clock no faster than 5 MHz: half period at least 100 ns
`define SMX_SCLK_HALF_NS 100
`define SMX_HALF_MIN_CYC \
	((`SMX_SCLK_HALF_NS + `SMX_SYS_PERIOD_NS - 1) / `SMX_SYS_PERIOD_NS)

// host controller registers, byte addresses
`define SMX_REG_DATA 8'h00
`define SMX_REG_CFG 8'h04
`define SMX_REG_CTRL 8'h08
`define SMX_REG_RX 8'h0c

// cfg fields: [2:0] devices in chain minus one, [15:8] half period cycles
`define SMX_CFG_NDEV_MSB 2
`define SMX_CFG_HALF_LSB 8
`define SMX_CFG_HALF_MSB 15
`define SMX_CFG_RESET 32'h0000_1900
`define SMX_CTRL_GO_POS 0
`define SMX_CTRL_BUSY_POS 0

`endif

// [hw/smx_sync2.sv]
`timescale 1ns/1ns
`default_nettype none

module smx_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk_i)
	begin
		meta <= d_i;
		q_o <= meta;
	end
endmodule

`default_nettype wire

// [verif/smx_link_asserts.sv]
`timescale 1ns/1ns
`default_nettype none

module smx_link_asserts (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic sel,
	input wire logic sel_high_o,
	input wire logic dout_oe,
	input wire logic dout_line,
	input wire logic [7:0] channel_on_o,
	input wire logic break_o,
	input wire logic [3:0] word_o
);
	logic [7:0] brk_n;
	logic [7:0] dec;

	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);

	// cycles spent in the current break gap
	always_ff @(posedge sys_clk_i)
		brk_n <= (reset_i || !break_o) ? 8'h00 : brk_n + 8'h01;

	assign dec = word_o[3] ? (8'h01 << word_o[2:0]) : 8'h00;

	oe_follows_a: assert property (dout_oe == sel)
		else $error("output enable not following select");
	line_released_a: assert property (!sel |-> dout_line)
		else $error("serial output driven with select low");
	one_hot_a: assert property ($onehot0(channel_on_o))
		else $error("more than one channel closed");
	break_open_a: assert property (break_o |-> channel_on_o == 8'h00)
		else $error("channel closed during break gap");
	break_start_a: assert property ($fell(sel) |-> ##[1:8] break_o)
		else $error("no break gap after select fall");
	gap_length_a: assert property ($fell(break_o) |-> brk_n >= 8'h20)
		else $error("break gap too short");
	off_quick_a: assert property ($fell(sel) |-> ##[1:100] !channel_on_o)
		else $error("old channel not opened in time");
	on_bound_a: assert property ($fell(sel) |-> ##[1:200] $fell(break_o))
		else $error("new channel not closed in time");
	decode_a: assert property ($fell(break_o) |-> ##[0:2] channel_on_o == dec)
		else $error("closed channel differs from word");
	hold_a: assert property (sel |-> $stable(channel_on_o))
		else $error("selection changed with select high");
	sel_seen_a: assert property (sel_high_o == $past(sel, 3))
		else $error("synchronised select out of step");

	cover property ($fell(break_o));
	cover property (channel_on_o[0]);
	cover property (channel_on_o[7]);
endmodule

`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o;
	logic [7:0] channel_on_o;
	logic break_o;
	logic [3:0] word_o;
	logic sel_high_o;
	logic [2:0] frame_bits_o;
	int errors = 0;
	int check_count = 0;

	always #2 sys_clk_i = ~sys_clk_i;

	smx_link_if link ();
	smx_host i_smx_host (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .link(link));
	smx_device i_smx_device (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.link(link), .channel_on_o(channel_on_o), .break_o(break_o),
		.word_o(word_o), .sel_high_o(sel_high_o),
		.frame_bits_o(frame_bits_o));
	smx_link_asserts i_smx_link_asserts (.sys_clk_i(sys_clk_i),
		.reset_i(reset_i), .sel(link.sel), .sel_high_o(sel_high_o),
		.dout_oe(link.dout_oe),
		.dout_line(link.dout_line), .channel_on_o(channel_on_o),
		.break_o(break_o), .word_o(word_o));

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] s);
		check_count++;
		if (s !== e)
		begin
			$display("MISMATCH %s exp %h got %h", n, e, s);
			errors++;
		end
	endtask

	task automatic print_verdict();
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask

	// load, start, poll busy, then allow the full turn-on delay
	task automatic send(input logic [31:0] d);
		logic [31:0] v;
		wr(8'h00, d);
		wr(8'h08, 32'h1);
		for (int i = 0; i < 500; i++)
		begin
			rd(8'h08, v);
			if (v[0] === 1'b0)
				break;
			if (i == 499)
			begin
				chk("busy", 32'h0, v);
				print_verdict();
			end
		end
		repeat (200) @(posedge sys_clk_i);
	endtask

	initial
	begin
		logic [31:0] v;
		logic [3:0] w;
		repeat (16) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		rd(8'h04, v);
		chk("cfg", 32'h0000_1900, v);
		rd(8'h10, v);
		chk("unmapped", 32'h0, v);
		for (int k = 0; k < 9; k++)
		begin
			w = (k == 8) ? 4'h5 : {1'b1, k[2:0]};
			send({28'h0, w});
			chk("word", {28'h0, w}, {28'h0, word_o});
			chk("chan", (k == 8) ? 32'h0 : 32'h1 << k, {24'h0, channel_on_o});
			chk("bits", k[0] ? 32'h0 : 32'h4, {29'h0, frame_bits_o});
			chk("sel_high", 32'h0, {31'h0, sel_high_o});
			if (k > 0)
			begin
				rd(8'h0c, v);
				chk("rx", {28'h0, 4'h7 + k[3:0]}, {28'h0, v[3:0]});
			end
		end
		// two words in one stream: the device keeps the nearer one
		// a half period below the minimum is raised to it
		wr(8'h04, 32'h0000_0501);
		rd(8'h04, v);
		chk("clamp", 32'h0000_1901, v);
		send(32'h0000_001c);
		chk("word2", 32'hc, {28'h0, word_o});
		chk("chan2", 32'h10, {24'h0, channel_on_o});
		chk("bits2", 32'h4, {29'h0, frame_bits_o});
		rd(8'h00, v);
		chk("data", 32'h0000_001c, v);
		rd(8'h0c, v);
		chk("rx2", 32'h51, {24'h0, v[7:0]});
		print_verdict();
	end
endmodule

`default_nettype wire
